// File: core/rx_filter_regs.vh
`ifndef RX_FILTER_REGS_VH
`define RX_FILTER_REGS_VH
`define PROTO_ISO14443A 2'h1
`define PROTO_ISO14443B 2'h2
`define ERR_BUF_DEPTH 4'h8
`define ERR_CODE_TIMEOUT 8'h87
`define ERR_CODE_LIMIT 8'h8e
`define ERR_CODE_PARTIAL 8'h8f
`endif

// File: core/rx_disturbance_filter.v
`timescale 1ns/1ps
`default_nettype none
`include "rx_filter_regs.vh"
module rx_disturbance_filter (
   input wire mclk, // System clock
   input wire rst_b, // Async reset, active low
   input wire reader_mode, // Device is a reader
   input wire [1:0] protocol, // Selected protocol
   input wire [7:0] max_invalid_bytes, // Invalid byte limit, zero disables
   input wire [7:0] max_invalid_partial_bytes, // Invalid partial byte limit
   input wire rx_start, // Pulse: reception attempt begins
   input wire sof_valid, // Pulse: valid start of frame
   input wire frame_ok, // Pulse: frame received correctly
   input wire rx_fail, // Pulse: reception failed
   input wire [7:0] fail_bytes, // Bytes in failed reception
   input wire fail_partial, // Failed reception ended in partial byte
   input wire [7:0] fail_code, // Error code of the failure
   input wire protocol_error, // Failure is a genuine protocol error
   input wire wait_timeout, // Pulse: FDT/FWT expired
   input wire [2:0] rd_index, // Error buffer read index
   output wire filter_active, // Filter running
   output reg deliver_frame, // Pulse: normal reception delivered
   output reg error_done, // Pulse: error reply ready
   output reg [7:0] last_error_code, // Last error raised
   output reg [3:0] error_buffer_length, // Stored error count
   output reg [7:0] rd_data // Error buffer entry at rd_index
);
   localparam st_idle = 1'b0;
   localparam st_wait = 1'b1;
   reg state;
   reg [7:0] invalid_cnt;
   reg [7:0] partial_cnt;
   reg [7:0] error_buffer [0:7];
   wire enabled = reader_mode && (max_invalid_bytes != 8'h00) &&
      (protocol == `PROTO_ISO14443A || protocol == `PROTO_ISO14443B);
   // Saturating add, so a long noise burst cannot wrap a counter below its limit
   function [7:0] sat_add;
      input [7:0] a;
      input [7:0] b;
      reg [8:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         sat_add = s[8] ? 8'hff : s[7:0];
      end
   endfunction
   wire [7:0] next_invalid = sat_add(invalid_cnt, fail_bytes);
   wire [7:0] next_partial = sat_add(partial_cnt, {7'h00, fail_partial});
   wire hit_invalid = next_invalid >= max_invalid_bytes;
   wire hit_partial = fail_partial && (next_partial >= max_invalid_partial_bytes);
   wire buf_room = error_buffer_length < `ERR_BUF_DEPTH;
   integer i;
   assign filter_active = (state == st_wait);
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_idle;
         invalid_cnt <= 8'h00;
         partial_cnt <= 8'h00;
         deliver_frame <= 1'b0;
         error_done <= 1'b0;
         last_error_code <= 8'h00;
         error_buffer_length <= 4'h0;
         rd_data <= 8'h00;
         for (i = 0; i < 8; i = i + 1) begin
            error_buffer[i] <= 8'h00;
         end
      end else begin
         deliver_frame <= 1'b0;
         error_done <= 1'b0;
         rd_data <= error_buffer[rd_index];
         case (state)
            st_idle: begin
               if (rx_start && enabled) begin
                  state <= st_wait;
                  invalid_cnt <= 8'h00;
                  partial_cnt <= 8'h00;
                  error_buffer_length <= 4'h0;
                  last_error_code <= 8'h00;
               end
            end
            st_wait: begin
               // Waits here with no host help
               if (frame_ok) begin
                  state <= st_idle;
                  deliver_frame <= 1'b1;
               end else if (wait_timeout) begin
                  state <= st_idle;
                  last_error_code <= `ERR_CODE_TIMEOUT;
                  error_done <= 1'b1;
               end else if (rx_fail) begin
                  invalid_cnt <= next_invalid;
                  partial_cnt <= next_partial;
                  last_error_code <= fail_code;
                  if (buf_room) begin
                     error_buffer[error_buffer_length[2:0]] <= fail_code;
                     error_buffer_length <= error_buffer_length + 4'h1;
                  end
                  if (protocol_error || hit_invalid || hit_partial) begin
                     state <= st_idle;
                     error_done <= 1'b1;
                     if (!protocol_error && hit_partial) begin
                        last_error_code <= `ERR_CODE_PARTIAL;
                     end else if (!protocol_error) begin
                        last_error_code <= `ERR_CODE_LIMIT;
                     end
                  end
               end
            end
            default: state <= st_idle;
         endcase
      end
   end
endmodule // rx_disturbance_filter
`default_nettype wire

// File: verification/rx_filter_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module rx_filter_monitor(input wire mclk,rst_b,reader_mode,rx_start,frame_ok,rx_fail,wait_timeout,
 protocol_error,filter_active,deliver_frame,error_done,input wire [7:0] max_invalid_bytes,
 last_error_code,input wire [3:0] error_buffer_length);
default clocking @(posedge mclk); endclocking
default disable iff (!rst_b);
wire on=filter_active;
wire go=rx_start&&!on;
property p_zero; go&&max_invalid_bytes==0|=>!on; endproperty
a_zero: assert property(p_zero) else $error("zero");
property p_mode; go&&!reader_mode|=>!on; endproperty
a_mode: assert property(p_mode) else $error("mode");
property p_clr; $rose(on)|->error_buffer_length==0; endproperty
a_clr: assert property(p_clr) else $error("clear");
property p_ok; on&&frame_ok|=>deliver_frame&&!on; endproperty
a_ok: assert property(p_ok) else $error("frame");
property p_tmo; on&&wait_timeout&&!frame_ok|=>error_done&&last_error_code==8'h87; endproperty
a_tmo: assert property(p_tmo) else $error("timeout");
property p_pe; on&&rx_fail&&protocol_error&&!frame_ok&&!wait_timeout|=>error_done&&!on; endproperty
a_pe: assert property(p_pe) else $error("protocol");
property p_len; error_buffer_length<=4'h8; endproperty
a_len: assert property(p_len) else $error("length");
property p_rep; error_done|->$past(on)&&!deliver_frame; endproperty
a_rep: assert property(p_rep) else $error("reply");
c_ok: cover property(deliver_frame);
c_full: cover property(error_done&&error_buffer_length==4'h8);
c_tmo: cover property(error_done&&last_error_code==8'h87);
c_part: cover property(error_done&&last_error_code==8'h8f);
endmodule // rx_filter_monitor
bind rx_disturbance_filter rx_filter_monitor mon_u(.*);
`default_nettype wire

// File: verification/tag_model.sv
`timescale 1ns/1ps
`default_nettype none
module tag_model(input wire mclk,output logic frame_ok=0,rx_fail=0,wait_timeout=0,
 protocol_error=0,fail_partial=0,output logic [7:0] fail_bytes=0,fail_code=0);
task ev(input [1:0] k,input [7:0] c,b,input p);
 @(negedge mclk) {frame_ok,wait_timeout,protocol_error,rx_fail}={k==1,k==2,k==3,k[0]==k[1]};
 {fail_bytes,fail_code}={b,c};
 fail_partial=p;
 // Released fields show garbage
 @(negedge mclk) {frame_ok,rx_fail,wait_timeout,fail_bytes,fail_code}={3'h0,~b,~c};
endtask
endmodule // tag_model
`default_nettype wire

// File: verification/rx_disturbance_filter_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin num_checks++; if((a)!==(b)) begin fail_count++; $display("[ERR] %0t %h %h",$time,a,b); end end
module rx_disturbance_filter_tb;
logic mclk=0,rst_b=0,reader_mode=1,rx_start=0,sof_valid=0; logic [1:0] protocol=1; logic [2:0] rd_index=0;
logic [7:0] max_invalid_bytes=0,max_invalid_partial_bytes=8'hff,c,q[$];
wire frame_ok,rx_fail,wait_timeout,protocol_error,fail_partial,filter_active,deliver_frame,error_done;
wire [7:0] fail_bytes,fail_code,last_error_code,rd_data; wire [3:0] error_buffer_length;
int fail_count=0,num_checks=0,n,i,t;
always #50 mclk=~mclk;
tag_model tm(.*);
rx_disturbance_filter dut_u(.*);
function [3:0] exp_len(int k); return k>8?8:k; endfunction
task end_of_test; $display("checks %0d fails %0d",num_checks,fail_count);
 if(fail_count==0&&num_checks>0) $display("Testbench passed");
 else $display("Testbench failed");
 $finish; endtask
task start; @(negedge mclk) rx_start=1; q.delete(); @(negedge mclk) rx_start=0; endtask
task fin(input [1:0] k,input [7:0] b,e,input p);
 c=$urandom; if(k[0]==k[1]) q.push_back(c);
 fork
  tm.ev(k,c,b,p);
  begin @(negedge mclk); for(n=0;n<4&&!(deliver_frame|error_done);n++) @(negedge mclk); end
 join
 if(n==4) begin fail_count++; end_of_test; end
 `CHK(deliver_frame,k==1)
 if(k!=1) begin `CHK(last_error_code,k==3?c:e) `CHK(error_buffer_length,exp_len(q.size())) end
 for(i=0;i<exp_len(q.size());i++) begin rd_index=i[2:0]; @(negedge mclk) `CHK(rd_data,q[i]) end
 $display("test end %0d",k); endtask
initial begin
 c=$urandom(32'h1f0fe44e); repeat(12) @(negedge mclk); rst_b=1;
 start; `CHK(filter_active,1'b0)
 max_invalid_bytes=8'hff; reader_mode=0; start; `CHK(filter_active,1'b0)
 reader_mode=1;
 for(t=0;t<8;t++) begin protocol=2'h1+t[0]; start; `CHK(filter_active,1'b1)
  n=t<2?t*10:$urandom%11; repeat(n) begin c=$urandom; q.push_back(c); tm.ev(0,c,1,1'b0); end
  fin(t[0]?2:(t[1]?3:1),1,8'h87,1'b0); end
 max_invalid_bytes=2; max_invalid_partial_bytes=2; start; fin(0,2,8'h8e,1'b0);
 max_invalid_bytes=8'h10; start; c=$urandom; q.push_back(c); tm.ev(0,c,1,1'b1);
 fin(0,1,8'h8f,1'b1);
 end_of_test;
end
endmodule // rx_disturbance_filter_tb
`default_nettype wire
